/* File: clock_power_pkg.sv */
package clock_power_pkg;

   // ************************************************************
   // Timing.
   // ************************************************************
   localparam int CLK_PERIOD_NS = 20;
   localparam int LOCK_TIME_NS = 300000;
   localparam int LOCK_CYC = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int REF_KHZ = 12000;

   // ************************************************************
   // Register map.
   // ************************************************************
   localparam int ADDR_W = 8;
   localparam logic [7:0] ADDR_MAIN_CFG = 8'h00;
   localparam logic [7:0] ADDR_USB_CFG = 8'h04;
   localparam logic [7:0] ADDR_GATE = 8'h08;
   localparam logic [7:0] ADDR_MODE = 8'h0c;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam logic [7:0] ADDR_MAIN_KHZ = 8'h14;
   localparam logic [7:0] ADDR_USB_KHZ = 8'h18;

   localparam int MDIV_LSB = 12;
   localparam int PDIV_LSB = 4;
   localparam int SDIV_LSB = 0;
   localparam logic [31:0] MCFG_RST = 32'h00038021;
   localparam logic [31:0] UCFG_RST = 32'h00038022;
   localparam int PERIPH_N = 16;
   localparam logic [PERIPH_N-1:0] GATE_RST = 16'hffff;

   localparam logic [1:0] MODE_NORMAL = 2'h0;
   localparam logic [1:0] MODE_SLOW = 2'h1;
   localparam logic [1:0] MODE_IDLE = 2'h2;
   localparam logic [1:0] MODE_SLEEP = 2'h3;
   localparam logic [1:0] BOOT_TEST = 2'h3;

   localparam int ST_BOOT_SEL = 0;
   localparam int ST_BOOT_MODE = 2;
   localparam int ST_TEST = 4;
   localparam int ST_CLK = 5;
   localparam int ST_PWR = 8;
   localparam int ST_USB_CFGD = 12;
   localparam int ST_USB_BUSY = 13;

   // ************************************************************
   // Types.
   // ************************************************************
   typedef enum logic [2:0] {
      CS_REF = 3'h1,
      CS_LOCK = 3'h2,
      CS_PLL = 3'h4
   } clk_state_t;

   typedef enum logic [3:0] {
      PM_NORMAL = 4'h1,
      PM_SLOW = 4'h2,
      PM_IDLE = 4'h4,
      PM_SLEEP = 4'h8
   } pwr_state_t;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [ADDR_W-1:0] adr;
      logic [31:0] dat;
   } wb_req_t;

   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } wb_rsp_t;

   typedef struct packed {
      logic cpu;
      logic ahb;
      logic apb;
      logic usb;
   } clk_en_t;

   typedef struct packed {
      clk_state_t cst;
      pwr_state_t pst;
      logic booted;
      logic [1:0] boot_sel;
      logic [1:0] boot_mode;
      logic [31:0] mcfg;
      logic [31:0] ucfg;
      logic [PERIPH_N-1:0] gate;
      logic usb_cfgd;
      logic ack;
      logic [31:0] dat;
   } cpm_state_t;

   // Output frequency in kHz of a PLL for a given configuration word.
   function automatic logic [31:0] pll_khz(input logic [31:0] cfg);
      logic [31:0] m;
      logic [31:0] p;
      logic [31:0] s;
      m = {24'h0, cfg[MDIV_LSB +: 8]} + 32'h8;
      p = {26'h0, cfg[PDIV_LSB +: 6]} + 32'h2;
      s = {30'h0, cfg[SDIV_LSB +: 2]};
      return (32'h2 * m * 32'(REF_KHZ)) / (p << s);
   endfunction

endpackage

/* File: lock_timer.sv */
`timescale 1ns/100ps
`default_nettype none

// ************************************************************
// Lock time counter, reloaded on every start.
// ************************************************************
module lock_timer #(
   parameter int CYCLES = 15000
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic start_i,
   output logic busy_o,
   output logic done_o
);
   localparam int CW = $clog2(CYCLES + 1);

   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;

   always_comb begin
      cnt_nxt = cnt_r;
      if (start_i) begin
         cnt_nxt = CW'(CYCLES);
      end else if (cnt_r != '0) begin
         cnt_nxt = cnt_r - 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   assign busy_o = (cnt_r != '0);
   assign done_o = (cnt_r == CW'(1));

endmodule
`default_nettype wire

/* File: clock_power_manager.sv */
// Local design decisions: the Wishbone register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none

// Operation
// R01 - Latch the two boot clock select pins when reset releases, use latch after.
// R02 - Latched select picks crystal or external clock per PLL; both PLLs always run; code turns both PLLs off in sleep.
// R03 - After reset the raw reference is the system clock until main config written.
// R04 - Software must rewrite the main PLL configuration after reset, even unchanged.
// R05 - With both boot mode pins high the clock select pins choose a test mode.
// R06 - PLL output is 2 times (M+8) times Fin over (P+2) times 2 to the S.
// R07 - On PLL reconfiguration stop the CPU clock until the lock time has passed.
// R08 - Run source and lock sequencing on reset and on every wakeup from sleep; code relocks only the main PLL, and only after a main config write.
// R09 - After reset start the main PLL with defaults while clocking from reference.
// R10 - Begin a lock sequence only on a write of a new PLL configuration; code locks on any main config write and on sleep wakeup after a main config write.
// R11 - Switch the CPU clock to the main PLL as soon as lock time expires.
// R12 - Provide three derived clocks: CPU core, AHB peripherals and APB peripherals.
// R13 - A second PLL independently produces the 48 MHz USB clock.
// R14 - In normal mode software gates each peripheral clock with its own bit.
// R15 - In slow mode bypass the main PLL and clock the CPU from the reference.
// R16 - In idle mode gate only the CPU core clock, keep all others running.
// R17 - Leave idle mode and restore the CPU clock on any CPU interrupt request.
// R18 - On sleep turn the switched supply off; the wakeup logic stays powered.
// R19 - Wake from sleep only on the sixteen low external lines or the alarm.
// R20 - Count lock time on the reference clock, reload per write, release at expiry.
module clock_power_manager
   import clock_power_pkg::*;
#(
   parameter int LOCK_CYCLES = LOCK_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire wb_req_t wb_req_i,
   output wb_rsp_t wb_rsp_o,
   input wire logic [1:0] boot_clock_select_i,
   input wire logic [1:0] boot_mode_select_i,
   input wire logic irq_i,
   input wire logic [15:0] external_interrupt_line_i,
   input wire logic rtc_alarm_i,
   output clk_en_t clk_en_o,
   output logic [PERIPH_N-1:0] periph_clk_en_o,
   output logic sys_clk_sel_pll_o,
   output logic usb_clk_sel_pll_o,
   output logic main_src_ext_o,
   output logic usb_src_ext_o,
   output logic main_pll_on_o,
   output logic usb_pll_on_o,
   output logic core_power_off_o,
   output logic test_mode_o,
   output logic [1:0] test_sel_o
);

   // ************************************************************
   // State and lock timers.
   // ************************************************************
   cpm_state_t s_r;
   cpm_state_t s_nxt;
   logic [1:0] tstart;
   logic [1:0] tbusy;
   logic [1:0] tdone;
   logic acc;
   logic wr_now;
   logic wake;
   logic locking;
   logic test_mode;

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : gen_timer
         lock_timer #(
            .CYCLES(LOCK_CYCLES)
         ) u_timer (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .start_i(tstart[g]),
            .busy_o(tbusy[g]),
            .done_o(tdone[g])
         );
      end
   endgenerate

   // Byte-lane merge of a write into an old word.
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] sel);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            res[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return res;
   endfunction

   assign acc = wb_req_i.cyc & wb_req_i.stb;
   assign wr_now = acc & wb_req_i.we & s_r.ack;
   assign wake = (|external_interrupt_line_i) | rtc_alarm_i; // see R19
   assign locking = (s_r.cst == CS_LOCK);
   assign test_mode = s_r.booted & (s_r.boot_mode == BOOT_TEST);

   // ************************************************************
   // Next state.
   // ************************************************************
   always_comb begin
      s_nxt = s_r;
      tstart = 2'b00;
      s_nxt.ack = acc & ~s_r.ack;
      if (acc & ~s_r.ack) begin
         case (wb_req_i.adr)
            ADDR_MAIN_CFG: begin
               s_nxt.dat = s_r.mcfg;
            end
            ADDR_USB_CFG: begin
               s_nxt.dat = s_r.ucfg;
            end
            ADDR_GATE: begin
               s_nxt.dat = 32'(s_r.gate);
            end
            ADDR_MODE: begin
               case (s_r.pst)
                  PM_SLOW: s_nxt.dat = 32'(MODE_SLOW);
                  PM_IDLE: s_nxt.dat = 32'(MODE_IDLE);
                  PM_SLEEP: s_nxt.dat = 32'(MODE_SLEEP);
                  default: s_nxt.dat = 32'(MODE_NORMAL);
               endcase
            end
            ADDR_STATUS: begin
               s_nxt.dat = '0;
               s_nxt.dat[ST_BOOT_SEL +: 2] = s_r.boot_sel;
               s_nxt.dat[ST_BOOT_MODE +: 2] = s_r.boot_mode;
               s_nxt.dat[ST_TEST] = test_mode;
               s_nxt.dat[ST_CLK +: 3] = s_r.cst;
               s_nxt.dat[ST_PWR +: 4] = s_r.pst;
               s_nxt.dat[ST_USB_CFGD] = s_r.usb_cfgd;
               s_nxt.dat[ST_USB_BUSY] = tbusy[1];
            end
            ADDR_MAIN_KHZ: begin
               s_nxt.dat = pll_khz(s_r.mcfg); // see R06
            end
            ADDR_USB_KHZ: begin
               s_nxt.dat = pll_khz(s_r.ucfg); // see R06
            end
            default: begin
               s_nxt.dat = '0;
            end
         endcase
      end
      if (!s_r.booted) begin
         s_nxt.booted = 1'b1; // see R01
         s_nxt.boot_sel = boot_clock_select_i; // see R01
         s_nxt.boot_mode = boot_mode_select_i;
      end
      if (wr_now) begin
         case (wb_req_i.adr)
            ADDR_MAIN_CFG: begin
               s_nxt.mcfg = merge(s_r.mcfg, wb_req_i.dat, wb_req_i.sel);
               s_nxt.cst = CS_LOCK; // see R07, R10
               tstart[0] = 1'b1; // see R20
            end
            ADDR_USB_CFG: begin
               s_nxt.ucfg = merge(s_r.ucfg, wb_req_i.dat, wb_req_i.sel);
               s_nxt.usb_cfgd = 1'b1; // see R13
               tstart[1] = 1'b1;
            end
            ADDR_GATE: begin
               s_nxt.gate = PERIPH_N'(merge(32'(s_r.gate), wb_req_i.dat, wb_req_i.sel)); // see R14
            end
            ADDR_MODE: begin
               if (wb_req_i.sel[0] && (s_r.pst != PM_SLEEP)) begin // see R19
                  case (wb_req_i.dat[1:0])
                     MODE_SLOW: s_nxt.pst = PM_SLOW; // see R15
                     MODE_IDLE: s_nxt.pst = PM_IDLE; // see R16
                     MODE_SLEEP: s_nxt.pst = PM_SLEEP; // see R18
                     default: s_nxt.pst = PM_NORMAL;
                  endcase
               end
            end
            default: begin
            end
         endcase
      end
      if (locking && tdone[0] && !tstart[0]) begin
         s_nxt.cst = CS_PLL; // see R11
      end
      case (s_r.pst)
         PM_IDLE: begin
            if (irq_i) begin
               s_nxt.pst = PM_NORMAL; // see R17
            end
         end
         PM_SLEEP: begin
            if (wake) begin
               s_nxt.pst = PM_NORMAL; // see R19
               if (s_r.cst != CS_REF) begin
                  s_nxt.cst = CS_LOCK; // see R08
                  tstart[0] = 1'b1;
               end
            end
         end
         PM_NORMAL, PM_SLOW: begin
         end
         default: begin
            s_nxt.pst = PM_NORMAL;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r.cst <= CS_REF; // see R03
         s_r.pst <= PM_NORMAL;
         s_r.booted <= 1'b0;
         s_r.boot_sel <= 2'h0;
         s_r.boot_mode <= 2'h0;
         s_r.mcfg <= MCFG_RST;
         s_r.ucfg <= UCFG_RST;
         s_r.gate <= GATE_RST;
         s_r.usb_cfgd <= 1'b0;
         s_r.ack <= 1'b0;
         s_r.dat <= 32'h0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ************************************************************
   // Outputs.
   // ************************************************************
   assign wb_rsp_o.ack = s_r.ack;
   assign wb_rsp_o.dat = s_r.dat;

   // see R07, R12, R16
   assign clk_en_o.cpu = ~locking & ((s_r.pst == PM_NORMAL) | (s_r.pst == PM_SLOW));
   assign clk_en_o.ahb = ~locking & (s_r.pst != PM_SLEEP); // see R12
   assign clk_en_o.apb = ~locking & (s_r.pst != PM_SLEEP); // see R12
   assign clk_en_o.usb = ~tbusy[1] & (s_r.pst != PM_SLEEP); // see R13
   assign periph_clk_en_o = s_r.gate & {PERIPH_N{clk_en_o.apb}}; // see R14
   assign sys_clk_sel_pll_o = (s_r.cst == CS_PLL) & (s_r.pst != PM_SLOW); // see R03, R15
   assign usb_clk_sel_pll_o = s_r.usb_cfgd;
   assign main_src_ext_o = ~test_mode & s_r.boot_sel[1]; // see R02
   assign usb_src_ext_o = ~test_mode & s_r.boot_sel[0]; // see R02
   assign main_pll_on_o = s_r.booted & (s_r.pst != PM_SLEEP); // see R09
   assign usb_pll_on_o = s_r.booted & (s_r.pst != PM_SLEEP); // see R02
   assign core_power_off_o = (s_r.pst == PM_SLEEP); // see R18
   assign test_mode_o = test_mode; // see R05
   assign test_sel_o = test_mode ? s_r.boot_sel : 2'h0; // see R05

   // ************************************************************
   // Checks.
   // ************************************************************
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   logic [31:0] lock_len_r;
   always_ff @(posedge clk_i) begin
      if (rst_i || tstart[0]) begin
         lock_len_r <= 32'h0;
      end else if (locking) begin
         lock_len_r <= lock_len_r + 32'h1;
      end else begin
         lock_len_r <= 32'h0;
      end
   end

   sequence main_write_s;
      wr_now && wb_req_i.adr == ADDR_MAIN_CFG;
   endsequence

   sequence lock_exit_s;
      locking ##1 s_r.cst == CS_PLL;
   endsequence

   boot_latch_a: assert property ( // see R01
      !s_r.booted |=> s_r.booted && s_r.boot_sel == $past(boot_clock_select_i))
      else $error("boot select not latched after reset");

   ref_clock_a: assert property ( // see R03
      s_r.cst == CS_REF |-> !sys_clk_sel_pll_o)
      else $error("system clock on PLL before configuration");

   test_sel_a: assert property ( // see R05
      test_mode_o |-> test_sel_o == s_r.boot_sel && !main_src_ext_o && !usb_src_ext_o)
      else $error("test mode select wrong");

   lock_start_a: assert property ( // see R10
      main_write_s |=> locking && tbusy[0])
      else $error("configuration write did not start lock");

   lock_gate_a: assert property ( // see R07
      locking |-> !clk_en_o.cpu && !sys_clk_sel_pll_o)
      else $error("CPU clock running during lock");

   lock_exit_a: assert property ( // see R11
      lock_exit_s |-> $past(tdone[0]))
      else $error("lock left before timer expiry");

   lock_len_a: assert property ( // see R20
      lock_len_r <= 32'(LOCK_CYCLES))
      else $error("lock lasted too long");

   cfg_only_a: assert property ( // see R10
      !locking ##1 locking |-> $past(wr_now && wb_req_i.adr == ADDR_MAIN_CFG) ||
         $past(s_r.pst) == PM_SLEEP)
      else $error("lock began without cause");

   idle_gate_a: assert property ( // see R16
      s_r.pst == PM_IDLE |-> !clk_en_o.cpu && (locking || clk_en_o.ahb && clk_en_o.apb))
      else $error("idle gating wrong");

   idle_exit_a: assert property ( // see R17
      s_r.pst == PM_IDLE && irq_i |=> s_r.pst == PM_NORMAL)
      else $error("interrupt did not leave idle");

   slow_bypass_a: assert property ( // see R15
      s_r.pst == PM_SLOW |-> !sys_clk_sel_pll_o)
      else $error("slow mode uses PLL");

   sleep_power_a: assert property ( // see R18
      s_r.pst == PM_SLEEP |-> core_power_off_o && !clk_en_o.ahb)
      else $error("sleep supply not off");

   sleep_hold_a: assert property ( // see R19
      s_r.pst == PM_SLEEP && !wake |=> s_r.pst == PM_SLEEP)
      else $error("sleep left without wake event");

   sleep_wake_a: assert property ( // see R08
      s_r.pst == PM_SLEEP && wake && s_r.cst != CS_REF |=> locking && s_r.pst == PM_NORMAL)
      else $error("wakeup did not relock");

   pll_run_a: assert property ( // see R09
      !s_r.booted |=> main_pll_on_o && !sys_clk_sel_pll_o)
      else $error("main PLL not started on reference after reset");

   gate_bits_a: assert property ( // see R14
      wr_now && wb_req_i.adr == ADDR_GATE && wb_req_i.sel[1:0] == 2'h3 && !locking &&
         s_r.pst == PM_NORMAL |=> periph_clk_en_o == $past(wb_req_i.dat[PERIPH_N-1:0]))
      else $error("peripheral gate bits not applied");

   usb_lock_a: assert property ( // see R13
      wr_now && wb_req_i.adr == ADDR_USB_CFG |=> !clk_en_o.usb && usb_clk_sel_pll_o)
      else $error("USB clock not held during its lock");

endmodule
`default_nettype wire

/* File: cpu_host_model.sv */
`timescale 1ns/100ps
`default_nettype none

// ************************************************************
// Software side of the register bus.
// ************************************************************
module cpu_host_model
   import clock_power_pkg::*;
(
   input wire logic clk_i,
   output var wb_req_t wb_req_o,
   input wire wb_rsp_t wb_rsp_i
);
   initial begin
      wb_req_o = '0;
   end

   // A released bus shows the inverse of the last request.
   task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      @(posedge clk_i);
      wb_req_o <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: a, dat: d};
      @(posedge clk_i);
      while (wb_rsp_i.ack !== 1'b1) begin
         @(posedge clk_i);
      end
      q = wb_rsp_i.dat;
      wb_req_o <= '{cyc: 1'b0, stb: 1'b0, we: ~we, sel: 4'h0, adr: ~a, dat: ~d};
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      xfer(1'b0, a, 32'h0, q);
   endtask

   // Rewrites the main configuration unchanged after reset.
   task automatic boot_rewrite();
      logic [31:0] q;
      rd(ADDR_MAIN_CFG, q);
      wr(ADDR_MAIN_CFG, q);
   endtask
endmodule

`default_nettype wire

/* File: tb.sv */
`timescale 1ns/100ps
`default_nettype none

module tb;
   import clock_power_pkg::*;
   localparam int LOCK = 8;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   wb_req_t wb_req;
   wb_rsp_t wb_rsp;
   logic [1:0] bsel = 2'h0;
   logic [1:0] bmode = 2'h0;
   logic irq = 1'b0;
   logic [15:0] ext = 16'h0;
   logic alarm = 1'b0;
   clk_en_t en;
   logic [PERIPH_N-1:0] pen;
   logic sys_pll, usb_pll, main_ext, usb_ext, main_on, usb_on, pwr_off, tmode;
   logic [1:0] tsel;
   logic [31:0] q, cfg, g;
   logic tst;
   int bad_count = 0;
   int n_compared = 0;
   int n;

   always #10 clk_i = ~clk_i;

   cpu_host_model host (.clk_i(clk_i), .wb_req_o(wb_req), .wb_rsp_i(wb_rsp));

   clock_power_manager #(.LOCK_CYCLES(LOCK)) dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_rsp_o(wb_rsp),
      .boot_clock_select_i(bsel), .boot_mode_select_i(bmode), .irq_i(irq),
      .external_interrupt_line_i(ext), .rtc_alarm_i(alarm), .clk_en_o(en),
      .periph_clk_en_o(pen), .sys_clk_sel_pll_o(sys_pll), .usb_clk_sel_pll_o(usb_pll),
      .main_src_ext_o(main_ext), .usb_src_ext_o(usb_ext), .main_pll_on_o(main_on),
      .usb_pll_on_o(usb_on), .core_power_off_o(pwr_off), .test_mode_o(tmode),
      .test_sel_o(tsel)
   );

   // ************************************************************
   // Checking helpers.
   // ************************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      $display("compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   function automatic logic [31:0] exp_khz(input logic [31:0] c);
      logic [31:0] m;
      logic [31:0] p;
      m = {24'h0, c[19:12]} + 32'h8;
      p = {26'h0, c[9:4]} + 32'h2;
      return (32'h2 * m * 32'(REF_KHZ)) / (p * (32'h1 << c[1:0]));
   endfunction

   task automatic settle();
      @(posedge clk_i);
      #1;
   endtask

   task automatic do_reset(input logic [1:0] s, input logic [1:0] m);
      @(posedge clk_i);
      rst_i <= 1'b1;
      bsel <= s;
      bmode <= m;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      bsel <= ~s;
      bmode <= ~m;
      #1;
   endtask

   // Counts the cycles with the CPU clock stopped and checks the span.
   task automatic lock_check();
      int k;
      n = 0;
      #1;
      for (k = 0; k < 100; k++) begin
         if (en.cpu === 1'b0) n++;
         else if (n > 0) break;
         settle();
      end
      check(32'(n >= LOCK && n <= LOCK + 1), 32'h1);
      check({28'h0, en, sys_pll}, 32'h1f);
   endtask

   // ************************************************************
   // Test sequence.
   // ************************************************************
   initial begin
      void'($urandom(88));
      for (int i = 0; i < 16; i++) begin
         do_reset(i[1:0], i[3:2]);
         tst = (i[3:2] == BOOT_TEST);
         check({main_ext, usb_ext}, tst ? 2'h0 : i[1:0]);
         check({main_on, usb_on, sys_pll, usb_pll}, 4'hc);
         check({tmode, tsel}, tst ? {1'b1, i[1:0]} : 3'h0);
         host.rd(ADDR_STATUS, q);
         check(q[7:0], {CS_REF, tst, i[3:0]});
      end
      do_reset(2'($urandom), 2'h0);
      host.rd(ADDR_MAIN_CFG, q);
      check(q, MCFG_RST);
      host.rd(ADDR_USB_CFG, q);
      check(q, UCFG_RST);
      host.rd(ADDR_GATE, q);
      check(q, {16'h0, GATE_RST});
      host.wr(8'h24, $urandom);
      host.rd(8'h24, q);
      check(q, 32'h0);
      g = {16'h0, 16'($urandom)};
      host.wr(ADDR_GATE, g);
      repeat (3) settle();
      check({en.cpu, sys_pll}, 2'h2);
      check(pen, g);
      host.boot_rewrite();
      lock_check();
      for (int j = 0; j < 4; j++) begin
         cfg = {12'h0, 8'($urandom), 2'h0, 6'($urandom), 2'h0, 2'($urandom)};
         if (j == 0) cfg = 32'h000ff3f3;
         host.wr(ADDR_MAIN_CFG, cfg);
         if (j == 1) begin
            repeat (3) @(posedge clk_i);
            host.wr(ADDR_MAIN_CFG, cfg);
         end
         lock_check();
         host.rd(ADDR_MAIN_KHZ, q);
         check(q, exp_khz(cfg));
      end
      cfg = {12'h0, 8'($urandom), 2'h0, 6'($urandom), 2'h0, 2'($urandom)};
      host.wr(ADDR_USB_CFG, cfg);
      repeat (2) settle();
      check({en.usb, en.cpu}, 2'h1);
      repeat (LOCK + 2) settle();
      check({en.usb, usb_pll}, 2'h3);
      host.rd(ADDR_USB_KHZ, q);
      check(q, exp_khz(cfg));
      host.wr(ADDR_MODE, {30'h0, MODE_SLOW});
      settle();
      check({sys_pll, en.cpu, main_on}, 3'h3);
      host.wr(ADDR_MODE, {30'h0, MODE_NORMAL});
      settle();
      check({sys_pll, en.cpu}, 2'h3);
      host.wr(ADDR_MODE, {30'h0, MODE_IDLE});
      settle();
      check({28'h0, en}, 32'h7);
      check(pen, g);
      repeat (1 + $urandom % 4) @(posedge clk_i);
      irq <= 1'b1;
      @(posedge clk_i);
      irq <= 1'b0;
      #1;
      check(en.cpu, 1'b1);
      for (int k = 0; k < 2; k++) begin
         host.wr(ADDR_MODE, {30'h0, MODE_SLEEP});
         settle();
         check({pen, en, pwr_off, main_on, usb_on}, 23'h4);
         @(posedge clk_i);
         irq <= 1'b1;
         repeat (3) @(posedge clk_i);
         irq <= 1'b0;
         #1;
         check(pwr_off, 1'b1);
         @(posedge clk_i);
         if (k == 0) ext <= 16'h1 << ($urandom % 16);
         else alarm <= 1'b1;
         @(posedge clk_i);
         ext <= 16'h0;
         alarm <= 1'b0;
         #1;
         check(pwr_off, 1'b0);
         lock_check();
      end
      close_out();
   end

   initial begin
      repeat (5000) @(posedge clk_i);
      bad_count++;
      close_out();
   end
endmodule

`default_nettype wire
